// ==== rtl/tmr_core.v ====
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tmr_consts.vh"
// 16-bit timer core seen through an 8-bit bus
module tmr_core #(
	parameter NF_LEN = `TMR_NF_LEN
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Register port
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Pins and sources
	input wire external_count_pin,
	input wire capture_pin,
	input wire comparator_output,
	input wire irq_ack_ovf,
	input wire irq_ack_cmpa,
	input wire irq_ack_cmpb,
	input wire irq_ack_cap,
	// Compare results, waveform outputs and interrupt request
	output reg match_a,
	output reg match_b,
	output reg wave_out_a,
	output reg wave_out_b,
	output reg irq
);
	// Storage
	// Running count, written whole from holder plus low byte
	reg [15:0] counter_value_reg;
	// Active compare values seen by the comparators
	reg [15:0] compare_reg_a_reg; // Active compare A
	reg [15:0] compare_reg_b_reg; // Active compare B
	// CPU side copies, moved across at the update point
	reg [15:0] buf_a_reg; // CPU side buffer A
	reg [15:0] buf_b_reg; // CPU side buffer B
	// Time stamp of the last accepted capture event
	reg [15:0] capture_reg_reg;
	// One holder for every 16-bit register, so pairs must not interleave
	reg [7:0] hold_reg; // Shared high-byte holder
	// Control bytes, plain single-byte access
	reg [7:0] control_reg_a_reg;
	reg [7:0] control_reg_b_reg;
	// Flags and their masks, same bit order
	reg [3:0] shared_flag_reg_reg;
	reg [3:0] shared_mask_reg_reg;
	// Prescaler runs whatever the clock select says
	reg [9:0] presc_reg; // Free running prescaler
	// Direction only matters in the up-down modes
	reg dir_down_reg; // Counting down in phase-correct
	// Decoded mode and clock select
	wire [3:0] wgm; // Waveform mode, four bits
	wire [2:0] csel; // Clock select field
	// Single-cycle edge pulses from the pin front ends
	wire ext_edge; // Count pin edge
	wire cap_edge; // Capture trigger edge
	// One-cycle count enable
	reg timer_tick;
	// Ceiling for the current mode
	reg [15:0] top;
	// High when compare writes wait for the update point
	reg buffered;
	// Up-down counting mode
	wire pwm_phase;
	// Counter at ceiling or at zero
	wire at_top;
	wire at_bot;
	// Compare buffer transfer strobe
	wire upd_point;
	// CPU write to the counter low byte
	wire cnt_wr;
	// Capture register serves as the ceiling
	wire cap_top;

	assign wgm = {control_reg_b_reg[`TMR_B_WGM3], control_reg_b_reg[`TMR_B_WGM2],
		control_reg_a_reg[1:0]};
	assign csel = control_reg_b_reg[2:0];

	tmr_edge_sync #(.FILT(2)) u_ext (
		.clk(clk),
		.nrst(nrst),
		.filt_en(1'b0),
		.rise_sel(csel[0]),
		.sig_in(external_count_pin),
		.edge_out(ext_edge)
	);

	// capture source is pin or comparator
	tmr_edge_sync #(.FILT(NF_LEN)) u_cap (
		.clk(clk),
		.nrst(nrst),
		.filt_en(control_reg_b_reg[`TMR_B_NOISE]),
		.rise_sel(control_reg_b_reg[`TMR_B_EDGE]),
		.sig_in(control_reg_b_reg[`TMR_B_ACSRC] ? comparator_output : capture_pin),
		.edge_out(cap_edge)
	);

	// tick selection from prescaler taps or pin
	always @* begin
		case (csel)
			3'h1: timer_tick = 1'b1;
			3'h2: timer_tick = (presc_reg[2:0] == 3'h7);
			3'h3: timer_tick = (presc_reg[5:0] == 6'h3F);
			3'h4: timer_tick = (presc_reg[7:0] == 8'hFF);
			3'h5: timer_tick = (presc_reg == 10'h3FF);
			3'h6: timer_tick = ext_edge;
			3'h7: timer_tick = ext_edge;
			default: timer_tick = 1'b0;
		endcase
	end

	// compare A as ceiling is the active value, buffered except in mode 4
	always @* begin
		case (wgm)
			4'h1, 4'h5: top = `TMR_TOP8;
			4'h2, 4'h6: top = `TMR_TOP9;
			4'h3, 4'h7: top = `TMR_TOP10;
			4'h4, 4'h9, 4'hB, 4'hF: top = compare_reg_a_reg;
			4'h8, 4'hA, 4'hC, 4'hE: top = capture_reg_reg;
			default: top = `TMR_MAX;
		endcase
		// Normal and clear-on-match write straight through
		buffered = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC);
	end

	// Phase-correct modes count up then down
	assign pwm_phase = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) ||
		(wgm[3] && !wgm[2]);
	assign at_top = (counter_value_reg == top);
	assign at_bot = (counter_value_reg == `TMR_BOTTOM);
	// update at top (fast) or bottom (phase)
	assign upd_point = timer_tick && (pwm_phase ? at_bot : at_top);
	assign cnt_wr = wr && (addr == `TMR_A_CNT_L);
	// Modes 8, 10, 12 and 14 use the capture register as ceiling,
	// so a trigger must not overwrite the running period there
	assign cap_top = wgm[3] && !wgm[0];

	// Prescaler, reset by command bit
	// A reset here shifts the phase of every prescaled tick
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc_reg <= 10'h000;
		end else if (wr && addr == `TMR_A_PSR && wdata[0]) begin
			presc_reg <= 10'h000;
		end else begin
			presc_reg <= presc_reg + 10'h001;
		end
	end

	// Counter and direction
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			counter_value_reg <= `TMR_RST16;
			dir_down_reg <= 1'b0;
		end else if (cnt_wr) begin
			counter_value_reg <= {hold_reg, wdata};
		end else if (timer_tick) begin
			// Up-down modes turn at both ends
			if (pwm_phase) begin
				// Turn down at the ceiling
				if (at_top) begin
					dir_down_reg <= 1'b1;
					counter_value_reg <= counter_value_reg - 16'h0001;
				end else if (at_bot) begin
					// Turn up at zero
					dir_down_reg <= 1'b0;
					counter_value_reg <= counter_value_reg + 16'h0001;
				end else if (dir_down_reg) begin
					counter_value_reg <= counter_value_reg - 16'h0001;
				end else begin
					counter_value_reg <= counter_value_reg + 16'h0001;
				end
			end else if (at_top) begin
				// Single-slope modes wrap to zero
				counter_value_reg <= `TMR_BOTTOM;
			end else begin
				counter_value_reg <= counter_value_reg + 16'h0001;
			end
		end
	end

	// Compare buffers, capture, holder and control
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			compare_reg_a_reg <= `TMR_RST16;
			compare_reg_b_reg <= `TMR_RST16;
			buf_a_reg <= `TMR_RST16;
			buf_b_reg <= `TMR_RST16;
			capture_reg_reg <= `TMR_RST16;
			hold_reg <= `TMR_RST8;
			control_reg_a_reg <= `TMR_RST8;
			control_reg_b_reg <= `TMR_RST8;
			shared_mask_reg_reg <= 4'h0;
		end else begin
			if (!buffered || upd_point) begin
				compare_reg_a_reg <= buf_a_reg;
				compare_reg_b_reg <= buf_b_reg;
			end
			// capture copies counter, not in capture-ceiling modes
			if (cap_edge && !cap_top) begin
				capture_reg_reg <= counter_value_reg;
			end
			if (wr) begin
				case (addr)
					// plain byte control access
					// Force bits are strobes only, never stored
					`TMR_A_CTRL_A: control_reg_a_reg <= {6'h00, wdata[1:0]};
					`TMR_A_CTRL_B: control_reg_b_reg <= wdata;
					// all high writes land in holder
					`TMR_A_CNT_H, `TMR_A_CMPA_H, `TMR_A_CMPB_H, `TMR_A_CAP_H: hold_reg <= wdata;
					`TMR_A_CMPA_L: buf_a_reg <= {hold_reg, wdata};
					`TMR_A_CMPB_L: buf_b_reg <= {hold_reg, wdata};
					`TMR_A_CAP_L: capture_reg_reg <= {hold_reg, wdata};
					`TMR_A_MASK: shared_mask_reg_reg <= wdata[3:0];
					default: hold_reg <= hold_reg;
				endcase
			end else if (rd) begin
				if (addr == `TMR_A_CNT_L) begin
					hold_reg <= counter_value_reg[15:8];
				end else if (addr == `TMR_A_CAP_L) begin
					hold_reg <= capture_reg_reg[15:8];
				end
			end
		end
	end

	// capture flag set with copy, cleared by one or ack
	always @(posedge clk or negedge nrst) begin : flags
		reg [3:0] set_v;
		reg [3:0] clr_v;
		if (!nrst) begin
			shared_flag_reg_reg <= 4'h0;
		end else begin
			set_v = 4'h0;
			set_v[`TMR_F_OVF] = timer_tick &&
				(pwm_phase ? at_bot : (wgm == 4'h0 ? counter_value_reg == `TMR_MAX : at_top));
			set_v[`TMR_F_CMPA] = timer_tick && counter_value_reg == compare_reg_a_reg;
			set_v[`TMR_F_CMPB] = timer_tick && counter_value_reg == compare_reg_b_reg;
			set_v[`TMR_F_CAP] = cap_edge && !cap_top;
			// Capture flag marks the ceiling when capture sets it
			if (cap_top) begin
				set_v[`TMR_F_CAP] = timer_tick && at_top;
			end
			clr_v = {irq_ack_cap, irq_ack_cmpa, irq_ack_cmpb, irq_ack_ovf};
			if (wr && addr == `TMR_A_FLAG) begin
				clr_v = clr_v | wdata[3:0];
			end
			shared_flag_reg_reg <= (shared_flag_reg_reg & ~clr_v) | set_v;
		end
	end

	// match to waveform side, force bits strobe it
	// compare A gives no wave in modes 11 and 15; as ceiling in modes 4 and 9 it still drives one
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			match_a <= 1'b0;
			match_b <= 1'b0;
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
			irq <= 1'b0;
		end else begin
			// Level while equal, plus one pulse per force strobe
			match_a <= (counter_value_reg == compare_reg_a_reg) ||
				(wr && addr == `TMR_A_CTRL_A && wdata[`TMR_A_FOCA]);
			match_b <= (counter_value_reg == compare_reg_b_reg) ||
				(wr && addr == `TMR_A_CTRL_A && wdata[`TMR_A_FOCB]);
			wave_out_a <= (wgm == 4'hB || wgm == 4'hF) ? 1'b0 :
				(counter_value_reg < compare_reg_a_reg);
			wave_out_b <= counter_value_reg < compare_reg_b_reg;
			// Request follows flags one cycle late
			irq <= |(shared_flag_reg_reg & shared_mask_reg_reg);
		end
	end

	// Read data one cycle after strobe
	// Zero outside the answer cycle so a bus OR stays clean
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				`TMR_A_CTRL_A: rdata <= control_reg_a_reg;
				`TMR_A_CTRL_B: rdata <= control_reg_b_reg;
				// Low byte read also fills the holder
				`TMR_A_CNT_L: rdata <= counter_value_reg[7:0];
				`TMR_A_CNT_H, `TMR_A_CAP_H: rdata <= hold_reg;
				`TMR_A_CMPA_L: rdata <= buf_a_reg[7:0];
				`TMR_A_CMPA_H: rdata <= buf_a_reg[15:8];
				`TMR_A_CMPB_L: rdata <= buf_b_reg[7:0];
				`TMR_A_CMPB_H: rdata <= buf_b_reg[15:8];
				`TMR_A_CAP_L: rdata <= capture_reg_reg[7:0];
				// Upper flag and mask bits read zero
				`TMR_A_FLAG: rdata <= {4'h0, shared_flag_reg_reg};
				`TMR_A_MASK: rdata <= {4'h0, shared_mask_reg_reg};
				// Unmapped reads zero
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== pkg/tmr_consts.vh ====
// Function
// - Four 16-bit registers, reached bytewise over 8 bits
// - One shared 8-bit high-byte holding register
// - Low-byte write loads whole register at once
// - Low-byte read copies high byte to holder
// - Compare register reads bypass the holding register
// - Tick from prescaler or count pin edge
// - No clock source selected, counter stands still
// - Compare continuously, set flag, offer match out
// - Compare registers double buffered, mode update point
// - Capture pin or comparator edge copies counter
// - Optional noise filter before capture edge detect
// - Ceiling fixed 00FF/01FF/03FF, compare A or capture
// - Counter bottom 0000, maximum FFFF
// - Compare A as PWM ceiling: buffered, no output in modes 11 and 15, output kept in mode 9
// - Four flags, shared flag and mask registers
// - Control registers plain single-byte read/write
// - Control bits keep legacy positions
// - CPU counter write beats any count action
// - Capture flag set with copy, cleared by one
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// Register addresses
`define TMR_A_CTRL_A 4'h0
`define TMR_A_CTRL_B 4'h1
`define TMR_A_CNT_L 4'h2
`define TMR_A_CNT_H 4'h3
`define TMR_A_CMPA_L 4'h4
`define TMR_A_CMPA_H 4'h5
`define TMR_A_CMPB_L 4'h6
`define TMR_A_CMPB_H 4'h7
`define TMR_A_CAP_L 4'h8
`define TMR_A_CAP_H 4'h9
`define TMR_A_FLAG 4'hA
`define TMR_A_MASK 4'hB
`define TMR_A_PSR 4'hC
// Flag and mask bit positions
`define TMR_F_CAP 3
`define TMR_F_CMPA 2
`define TMR_F_CMPB 1
`define TMR_F_OVF 0
// Control B fields
`define TMR_B_NOISE 7
`define TMR_B_EDGE 6
`define TMR_B_ACSRC 5
`define TMR_B_WGM3 4
`define TMR_B_WGM2 3
// Control A fields
`define TMR_A_FOCA 3
`define TMR_A_FOCB 2
// Fixed ceilings and limits
`define TMR_TOP8 16'h00FF
`define TMR_TOP9 16'h01FF
`define TMR_TOP10 16'h03FF
`define TMR_BOTTOM 16'h0000
`define TMR_MAX 16'hFFFF
// Reset values
`define TMR_RST16 16'h0000
`define TMR_RST8 8'h00
// Noise filter depth
`define TMR_NF_LEN 4
`endif

// ==== rtl/tmr_edge_sync.v ====
`timescale 1ns/10ps
`default_nettype none
// Synchroniser, optional spike filter and edge detector
module tmr_edge_sync #(
	parameter FILT = 4
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Control
	input wire filt_en,
	input wire rise_sel,
	// Signal
	input wire sig_in,
	output reg edge_out
);
	reg s1_reg; // First stage, read only by s2
	reg s2_reg;
	reg [FILT-1:0] hist_reg; // Filter history
	reg filt_reg; // Filtered level
	reg prev_reg; // Level one cycle ago
	wire cur;
	wire all1;
	wire all0;
	assign all1 = &{hist_reg, s2_reg};
	assign all0 = ~|{hist_reg, s2_reg};
	// Filter only changes on agreeing samples, spikes die out
	assign cur = filt_en ? filt_reg : s2_reg;
	// Sample, filter and detect
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			hist_reg <= {FILT{1'b0}};
			filt_reg <= 1'b0;
			prev_reg <= 1'b0;
			edge_out <= 1'b0;
		end else begin
			s1_reg <= sig_in;
			s2_reg <= s1_reg;
			hist_reg <= {hist_reg[FILT-2:0], s2_reg};
			if (all1) begin
				filt_reg <= 1'b1;
			end else if (all0) begin
				filt_reg <= 1'b0;
			end
			prev_reg <= cur;
			edge_out <= rise_sel ? (cur & ~prev_reg) : (~cur & prev_reg);
		end
	end
endmodule
`default_nettype wire

// ==== testbench/tmr_core_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checker for the timer core register port
module tmr_core_chk #(
	parameter NF_LEN = 4
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Register port
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	// Outputs
	input wire irq
);
	// One domain, so one clocking and one disable
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Read data stands only in the answer cycle
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data seen outside answer cycle");
	chk_unmapped_zero: assert property (rd && addr >= 4'hD |=> rdata == 8'h00)
		else $error("unmapped address read not zero");
	chk_ctrl_readback: assert property (rd && addr == 4'h1 && $past(wr && addr == 4'h1)
		|=> rdata == $past(wdata, 2))
		else $error("control B readback differs from write");
	// Compare high byte comes straight from the register
	chk_cmpa_direct: assert property (rd && addr == 4'h5 && $past(rd && addr == 4'h4)
		&& $past(wr && addr == 4'h4, 2) && $past(wr && addr == 4'h5, 3)
		|=> rdata == $past(wdata, 4))
		else $error("compare A high byte not as loaded");
	// Holder written through the counter address feeds compare A
	chk_holder_share: assert property (rd && addr == 4'h5 && $past(rd && addr == 4'h4)
		&& $past(wr && addr == 4'h4, 2) && $past(wr && addr == 4'h3, 3)
		|=> rdata == $past(wdata, 4))
		else $error("shared holder not used for compare A");
	chk_irq_masked: assert property (wr && addr == 4'hB && wdata == 8'h00
		##1 !(wr && addr == 4'hB) |=> !irq)
		else $error("interrupt request with all sources masked");
	chk_flag_upper: assert property (rd && addr == 4'hA |=> rdata[7:4] == 4'h0)
		else $error("unused flag bits read nonzero");
	chk_force_read0: assert property (rd && addr == 4'h0 |=> rdata[3:2] == 2'b00)
		else $error("force bits read back nonzero");

	// Main scenarios reached
	cover property (rd && addr == 4'h8);
	cover property ($rose(irq));
	cover property (rd && addr == 4'h5 && $past(rd && addr == 4'h4));
endmodule
bind tmr_core tmr_core_chk #(.NF_LEN(NF_LEN)) u_chk (
	.clk(clk),
	.nrst(nrst),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.irq(irq)
);
`default_nettype wire

// ==== testbench/tmr_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Far-side pin source: n pulses of given width on one chosen line
module tmr_pin_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Command
	input wire logic go,
	input wire logic [1:0] sel,
	input wire logic [7:0] width,
	input wire logic [7:0] n,
	// Pins
	output logic external_count_pin,
	output logic capture_pin,
	output logic comparator_output
);
	logic [7:0] t_reg; // Cycles left in this half
	logic [7:0] w_reg; // Half width
	logic [7:0] left_reg; // Pulses still to send
	logic [1:0] s_reg; // Chosen line
	logic lvl_reg; // Current level
	// Pulse train; lines idle low so no stray edge between commands
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			{t_reg, w_reg, left_reg, s_reg, lvl_reg} <= '0;
		end else if (go) begin
			{s_reg, w_reg, t_reg, left_reg, lvl_reg} <= {sel, width, width, n, 1'b1};
		end else if (left_reg != 8'h00) begin
			if (t_reg == 8'h01) begin
				t_reg <= w_reg;
				lvl_reg <= !lvl_reg;
				if (lvl_reg) left_reg <= left_reg - 8'h01;
			end else t_reg <= t_reg - 8'h01;
		end
	end
	// count pin, capture pin or comparator
	assign external_count_pin = lvl_reg && s_reg == 2'h0;
	assign capture_pin = lvl_reg && s_reg == 2'h1;
	assign comparator_output = lvl_reg && s_reg == 2'h2;
endmodule
`default_nettype wire

// ==== testbench/tb_timer16_core_byte_access.sv ====
`timescale 1ns/10ps
`default_nettype none
// Register-level bench for the timer core
module tb_timer16_core_byte_access;
	logic clk = 0, nrst = 0, wr = 0, rd = 0, go = 0, pend = 0;
	logic [3:0] addr = 4'h0, ack = 4'h0;
	logic [7:0] wdata = 8'h00, exp_n = 8'h00, msk_n = 8'h00, exp_q, msk_q, width = 8'h00, n = 8'h00;
	logic [1:0] sel = 2'h0;
	wire [7:0] rdata;
	wire irq, ecp, cpin, cmpo;
	integer failures = 0, compares = 0, cyc = 0;
	// Device and pin source
	tmr_core #(.NF_LEN(4)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .external_count_pin(ecp), .capture_pin(cpin),
		.comparator_output(cmpo), .irq_ack_ovf(ack[0]), .irq_ack_cmpb(ack[1]),
		.irq_ack_cmpa(ack[2]), .irq_ack_cap(ack[3]), .match_a(), .match_b(), .wave_out_a(),
		.wave_out_b(), .irq(irq));
	tmr_pin_model u_pins (.clk(clk), .nrst(nrst), .go(go), .sel(sel), .width(width), .n(n),
		.external_count_pin(ecp), .capture_pin(cpin), .comparator_output(cmpo));
	// Clock at 100 MHz
	initial begin
		forever #5 clk = !clk;
	end
	task report_and_stop;
		$display("counts: compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task cmp(input [7:0] g, input [7:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Answer is sampled one edge after the read was taken
	always @(posedge clk) begin
		cyc++;
		if (pend) cmp(rdata & msk_q, exp_q);
		pend <= rd;
		exp_q <= exp_n;
		msk_q <= msk_n;
		// Hang guard
		if (cyc == 5000) begin
			failures++;
			report_and_stop;
		end
	end
	// Strobes stay up into the next call, so accesses run back to back
	task wr_c(input [3:0] a, input [7:0] d);
		@(posedge clk);
		{wr, rd, addr, wdata} <= {1'b1, 1'b0, a, d};
	endtask
	task rd_c(input [3:0] a, input [7:0] e, input [7:0] m);
		@(posedge clk);
		{wr, rd, addr, exp_n, msk_n} <= {1'b0, 1'b1, a, e, m};
	endtask
	task idle(input integer c);
		repeat (c) begin
			@(posedge clk);
			{wr, rd} <= 2'b00;
		end
	endtask
	// High byte first on write, low byte first on read
	task wr16(input [3:0] b, input [15:0] v);
		wr_c(b + 4'h1, v[15:8]);
		wr_c(b, v[7:0]);
	endtask
	task rd16(input [3:0] b, input [15:0] v);
		rd_c(b, v[7:0], 8'hFF);
		rd_c(b + 4'h1, v[15:8], 8'hFF);
	endtask
	task pins(input [1:0] s, input [7:0] w, input [7:0] k);
		@(posedge clk);
		{wr, rd, sel, width, n, go} <= {2'b00, s, w, k, 1'b1};
		@(posedge clk);
		go <= 1'b0;
	endtask
	task ackp(input [3:0] v);
		@(posedge clk);
		{wr, rd, ack} <= {2'b00, v};
		@(posedge clk);
		ack <= 4'h0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd16(4'h2, 16'h0000);
		rd16(4'h8, 16'h0000);
		rd_c(4'hA, 8'h00, 8'hFF);
		idle(20);
		rd16(4'h2, 16'h0000);
		wr16(4'h2, 16'h1234);
		rd16(4'h2, 16'h1234);
		wr_c(4'h3, 8'hAB);
		wr_c(4'h4, 8'h56);
		rd_c(4'h4, 8'h56, 8'hFF);
		rd_c(4'h5, 8'hAB, 8'hFF);
		rd_c(4'h2, 8'h34, 8'hFF);
		rd_c(4'h6, 8'h00, 8'hFF);
		rd_c(4'h5, 8'hAB, 8'hFF);
		rd_c(4'h3, 8'h12, 8'hFF);
		wr16(4'h4, 16'hC3A5);
		rd16(4'h4, 16'hC3A5);
		wr_c(4'h1, 8'hC8);
		rd_c(4'h1, 8'hC8, 8'hFF);
		wr_c(4'h0, 8'h0F);
		rd_c(4'h0, 8'h03, 8'hFF);
		wr_c(4'h0, 8'h00);
		wr_c(4'h1, 8'h00);
		rd_c(4'hD, 8'h00, 8'hFF);
		rd_c(4'hF, 8'h00, 8'hFF);
		// Wrap through MAX with both compares passed on the way
		wr_c(4'hA, 8'h0F);
		wr16(4'h6, 16'h0002);
		wr16(4'h4, 16'h0001);
		wr16(4'h2, 16'hFFFE);
		wr_c(4'hB, 8'h0F);
		wr_c(4'h1, 8'h01);
		idle(10);
		wr_c(4'h1, 8'h00);
		rd_c(4'hA, 8'h07, 8'h0F);
		idle(2);
		#1 cmp({7'h00, irq}, 8'h01);
		ackp(4'h2);
		wr_c(4'hA, 8'h01);
		rd_c(4'hA, 8'h04, 8'h0F);
		wr_c(4'hB, 8'h00);
		idle(3);
		#1 cmp({7'h00, irq}, 8'h00);
		wr_c(4'hA, 8'h0F);
		// Fixed 8-bit ceiling, fast mode
		wr16(4'h2, 16'h0000);
		wr_c(4'h0, 8'h01);
		wr_c(4'h1, 8'h09);
		idle(700);
		wr_c(4'h1, 8'h00);
		rd_c(4'h2, 8'h00, 8'h00);
		rd_c(4'h3, 8'h00, 8'hFF);
		wr_c(4'h0, 8'h00);
		// Rising edges on the count pin
		wr16(4'h2, 16'h0000);
		wr_c(4'h1, 8'h07);
		pins(2'h0, 8'h03, 8'h05);
		idle(40);
		wr_c(4'h1, 8'h00);
		rd16(4'h2, 16'h0005);
		// Capture from pin, rising edge
		wr_c(4'hA, 8'h0F);
		wr16(4'h2, 16'h0777);
		wr_c(4'h1, 8'h40);
		pins(2'h1, 8'h08, 8'h01);
		idle(20);
		rd_c(4'hA, 8'h08, 8'h08);
		rd16(4'h8, 16'h0777);
		wr_c(4'hA, 8'h08);
		rd_c(4'hA, 8'h00, 8'h08);
		// Comparator source through the spike filter
		wr16(4'h2, 16'h0999);
		wr_c(4'h1, 8'hE0);
		pins(2'h2, 8'h02, 8'h01);
		idle(20);
		rd_c(4'hA, 8'h00, 8'h08);
		pins(2'h2, 8'h0C, 8'h01);
		idle(30);
		rd_c(4'hA, 8'h08, 8'h08);
		rd16(4'h8, 16'h0999);
		ackp(4'h8);
		rd_c(4'hA, 8'h00, 8'h08);
		idle(3);
		report_and_stop;
	end
endmodule
`default_nettype wire
